/* include/ldr_pkg.sv */
// constants and types shared by the descriptor ring manager
package ldr_pkg;
  // ==========
  // timing
  localparam logic [7:0] POLL_CYCLES = 8'h28; // 1600 ns re-poll gap at 40 ns
  // ==========
  // registers
  localparam logic [4:0]  OFS_CTRL       = 5'h00;
  localparam logic [4:0]  OFS_RX_RING    = 5'h04;
  localparam logic [4:0]  OFS_TX_RING    = 5'h08;
  localparam logic [4:0]  OFS_STATUS     = 5'h0C;
  localparam int          CTRL_START_BIT = 0;
  localparam int          STAT_MISSED    = 24;
  localparam logic [31:0] RING_MASK      = 32'h07FFFFF8;
  localparam logic [31:0] RING_RESET     = 32'h00000000;
  localparam int          RING_CODE_LSB  = 24;
  // ==========
  // descriptor layout
  localparam int          DESC_SHIFT    = 3;
  localparam logic [23:0] DW_ADDR_LO    = 24'h000000;
  localparam logic [23:0] DW_STATUS     = 24'h000002;
  localparam logic [23:0] DW_LENGTH     = 24'h000004;
  localparam logic [23:0] DW_PKT_LENGTH = 24'h000006;
  localparam int W1_OWN      = 15;
  localparam int W1_FAULT    = 14;
  localparam int W1_FRAMING  = 13;
  localparam int W1_OVERFLOW = 12;
  localparam int W1_CRC      = 11;
  localparam int W1_STARVED  = 10;
  localparam int W1_FIRST    = 9;
  localparam int W1_LAST     = 8;
  localparam logic [3:0] PKT_LEN_PAD = 4'h0;
  // ==========
  // state machines
  typedef enum logic [3:0] {
    RX_STOP      = 4'h0,
    RX_OWN       = 4'h1,
    RX_ADDR      = 4'h3,
    RX_LEN       = 4'h2,
    RX_READY     = 4'h6,
    RX_LOOK      = 4'h7,
    RX_CLOSE_LEN = 4'h5,
    RX_CLOSE_OWN = 4'h4,
    RX_WAIT      = 4'hC
  } ldr_rx_state_t;
  typedef enum logic [2:0] {
    TX_STOP  = 3'h0,
    TX_OWN   = 3'h1,
    TX_ADDR  = 3'h3,
    TX_LEN   = 3'h2,
    TX_SEND  = 3'h6,
    TX_CLOSE = 3'h7,
    TX_WAIT  = 3'h5
  } ldr_tx_state_t;
endpackage

/* hdl/ldr_ring_index.sv */
// current-position index and descriptor addresses of one ring
`timescale 1ns/10ps
module ldr_ring_index (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // ring setup and control
  input  wire logic [23:0] ring_base,
  input  wire logic [2:0]  count_code,
  input  wire logic        clear,
  input  wire logic        advance,
  // position
  output logic      [6:0]  index,
  output logic      [23:0] desc_addr,
  output logic      [23:0] next_addr
);
  // ==========
  // index
  logic [7:0]  span;
  logic [6:0]  wrap_mask;
  logic [6:0]  index_next;
  logic [23:0] base_aligned;

  assign span       = 8'h01 << count_code;
  assign wrap_mask  = 7'(span - 8'h01);
  assign index_next = (index + 7'h01) & wrap_mask;

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      index <= 7'h00;
    end else if (advance) begin
      index <= index_next;
    end
  end

  // ==========
  // addresses: base plus eight bytes per descriptor
  assign base_aligned = {ring_base[23:3], 3'h0};
  assign desc_addr = base_aligned + {14'h0, index, 3'h0};
  assign next_addr = base_aligned + {14'h0, index_next, 3'h0};
endmodule // ldr_ring_index

/* hdl/ldr_ring_manager.sv */
// receive and transmit descriptor ring manager with avalon register slave
// Notes on behaviour
// - 8-byte descriptors, 8-byte aligned
// - ring index advances, wraps to zero
// - 24-bit ring base, low bits zero
// - descriptor n at base plus 8n
// - poll rings, move data, update status
// - look one descriptor ahead only
// - hand over only, then hands off
// - bit 15 owner, written last
// - fault summary ORs four faults
// - framing: odd bits with crc fault
// - overflow fault on queue overflow
// - crc fault on bad crc
// - starved flag, retry until overflow
// - first segment on first buffer
// - last segment on last buffer
// - host writes buffer address
// - code v gives 2^v descriptors
// - word two holds negated length
// - word three holds packet length
// - one packet per buffer at most
`timescale 1ns/10ps
module ldr_ring_manager (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // avalon-mm register slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // buffer ram master
  output logic             mem_req,
  output logic             mem_we,
  output logic      [23:0] mem_addr,
  output logic      [15:0] mem_wdata,
  output logic      [1:0]  mem_be,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  // received byte stream
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  input  wire logic        rx_crc_bad,
  input  wire logic        rx_dribble,
  // transmit engine
  output logic             tx_req,
  output logic      [23:0] tx_buf_addr,
  output logic      [11:0] tx_buf_length,
  output logic             tx_first_segment,
  output logic             tx_last_segment,
  input  wire logic        tx_done
);
  // ==========
  // register slave
  logic        ctrl_start_reg;
  logic [31:0] rx_ring_reg;
  logic [31:0] tx_ring_reg;
  logic        missed_reg;
  logic        bus_ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;
  logic        wr_en;
  logic [31:0] be_mask;
  ldr_pkg::ldr_rx_state_t rx_state_reg;
  ldr_pkg::ldr_tx_state_t tx_state_reg;
  logic [6:0]  rx_index;
  logic [6:0]  tx_index;

  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
                    {8{avs_byteenable[0]}}};

  // one wait cycle on every access keeps the read mux off the bus path
  assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_reg;
  assign wr_en           = avs_write & bus_ack_reg;
  assign avs_readdata    = rdata_reg;

  always_comb begin
    rd_mux = 32'h00000000;
    case (avs_address)
      ldr_pkg::OFS_CTRL:    rd_mux = {31'h0, ctrl_start_reg};
      ldr_pkg::OFS_RX_RING: rd_mux = rx_ring_reg;
      ldr_pkg::OFS_TX_RING: rd_mux = tx_ring_reg;
      ldr_pkg::OFS_STATUS:  rd_mux = {7'h0, missed_reg, 4'h0, rx_state_reg, 1'b0, tx_index,
                                      1'b0, rx_index};
      default:              rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_ack_reg <= 1'b0;
      rdata_reg   <= 32'h00000000;
    end else begin
      bus_ack_reg <= (avs_read | avs_write) & ~bus_ack_reg;
      if (avs_read && !bus_ack_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_start_reg <= 1'b0;
      rx_ring_reg    <= ldr_pkg::RING_RESET;
      tx_ring_reg    <= ldr_pkg::RING_RESET;
    end else if (wr_en) begin
      if (avs_address == ldr_pkg::OFS_CTRL && avs_byteenable[0]) begin
        ctrl_start_reg <= avs_writedata[ldr_pkg::CTRL_START_BIT];
      end
      if (avs_address == ldr_pkg::OFS_RX_RING) begin
        rx_ring_reg <= (rx_ring_reg & ~be_mask | avs_writedata & be_mask) & ldr_pkg::RING_MASK;
      end
      if (avs_address == ldr_pkg::OFS_TX_RING) begin
        tx_ring_reg <= (tx_ring_reg & ~be_mask | avs_writedata & be_mask) & ldr_pkg::RING_MASK;
      end
    end
  end

  // ==========
  // rings
  logic        rx_advance;
  logic        tx_advance;
  logic [23:0] rx_desc;
  logic [23:0] rx_next;
  logic [23:0] tx_desc;

  ldr_ring_index u_rx_ring (
    .clk        (clk),
    .rst        (rst),
    .ring_base  (rx_ring_reg[23:0]),
    .count_code (rx_ring_reg[ldr_pkg::RING_CODE_LSB +: 3]),
    .clear      (~ctrl_start_reg),
    .advance    (rx_advance),
    .index      (rx_index),
    .desc_addr  (rx_desc),
    .next_addr  (rx_next)
  );

  ldr_ring_index u_tx_ring (
    .clk        (clk),
    .rst        (rst),
    .ring_base  (tx_ring_reg[23:0]),
    .count_code (tx_ring_reg[ldr_pkg::RING_CODE_LSB +: 3]),
    .clear      (~ctrl_start_reg),
    .advance    (tx_advance),
    .index      (tx_index),
    .desc_addr  (tx_desc),
    .next_addr  ()
  );

  // ==========
  // buffer ram arbiter, receive first
  logic        rx_want, rx_we, tx_want, tx_we;
  logic [23:0] rx_addr, tx_addr;
  logic [15:0] rx_wdata, tx_wdata;
  logic [1:0]  rx_be;
  logic        owner_tx_reg, rx_ack, tx_ack;

  assign rx_ack = mem_req & mem_ack & ~owner_tx_reg;
  assign tx_ack = mem_req & mem_ack & owner_tx_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_req      <= 1'b0;
      mem_we       <= 1'b0;
      mem_addr     <= 24'h000000;
      mem_wdata    <= 16'h0000;
      mem_be       <= 2'h0;
      owner_tx_reg <= 1'b0;
    end else if (mem_req) begin
      if (mem_ack) begin
        mem_req <= 1'b0;
      end
    end else if (rx_want) begin
      {mem_req, mem_we, mem_addr, mem_wdata, mem_be} <= {1'b1, rx_we, rx_addr, rx_wdata, rx_be};
      owner_tx_reg <= 1'b0;
    end else if (tx_want) begin
      {mem_req, mem_we, mem_addr, mem_wdata, mem_be} <= {1'b1, tx_we, tx_addr, tx_wdata, 2'h3};
      owner_tx_reg <= 1'b1;
    end
  end

  // ==========
  // receive byte holding word
  logic [15:0] hold_data;
  logic [1:0]  hold_be;
  logic        hold_half, hold_full, hold_last;
  logic        pkt_open_reg, in_pkt_reg, drop_reg, end_pend_reg;
  logic        take, start_ok, hold_written;

  // a new packet only starts in a fresh, empty buffer
  assign start_ok = ~pkt_open_reg & ~in_pkt_reg & (rx_state_reg == ldr_pkg::RX_READY);
  assign take     = rx_valid & ~drop_reg & ~hold_full & (pkt_open_reg | start_ok);
  assign hold_written = rx_ack & (rx_state_reg == ldr_pkg::RX_READY);

  always_ff @(posedge clk) begin
    if (rst || !ctrl_start_reg) begin
      {hold_half, hold_full, hold_last, pkt_open_reg, drop_reg} <= 5'h00;
      hold_data <= 16'h0000;
      hold_be   <= 2'h0;
    end else begin
      if (hold_written) begin
        hold_full <= 1'b0;
        hold_last <= 1'b0;
      end
      if (take && !hold_half) begin
        hold_data[7:0] <= rx_data;
        hold_half      <= ~rx_last;
        hold_full      <= rx_last;
        hold_last      <= rx_last;
        hold_be        <= 2'h1;
      end else if (take) begin
        hold_data[15:8] <= rx_data;
        hold_half       <= 1'b0;
        hold_full       <= 1'b1;
        hold_last       <= rx_last;
        hold_be         <= 2'h3;
      end
      if (take) begin
        pkt_open_reg <= ~rx_last;
      end else if (rx_valid && rx_last) begin
        pkt_open_reg <= 1'b0;
      end
      if (rx_valid && rx_last) begin
        drop_reg <= 1'b0;
      end else if (rx_valid && !take) begin
        drop_reg <= 1'b1;
      end
    end
  end

  // ==========
  // receive ring walker
  logic [7:0]  buf_hi, next_hi;
  logic [15:0] buf_lo;
  logic [11:0] buf_len, buf_cnt, pkt_len, nbytes;
  logic [7:0]  rx_poll_cnt;
  logic        seg_first, last_reg;
  logic        f_fram, f_ovf, f_crc, f_starved, fault, rx_end_now;
  logic [15:0] rx_status_word;

  assign nbytes = (hold_be == 2'h3) ? 12'h002 : 12'h001;
  assign fault  = f_fram | f_ovf | f_crc | f_starved;
  assign rx_end_now = end_pend_reg & ~hold_full & ~hold_half;
  assign rx_status_word = {1'b0, fault, f_fram, f_ovf, f_crc, f_starved, seg_first, last_reg,
                           buf_hi};

  always_comb begin
    rx_want  = 1'b0;
    rx_we    = 1'b0;
    rx_addr  = rx_desc + ldr_pkg::DW_STATUS;
    rx_wdata = rx_status_word;
    rx_be    = 2'h3;
    case (rx_state_reg)
      ldr_pkg::RX_OWN:       rx_want = 1'b1;
      ldr_pkg::RX_ADDR: begin
        rx_want = 1'b1;
        rx_addr = rx_desc + ldr_pkg::DW_ADDR_LO;
      end
      ldr_pkg::RX_LEN: begin
        rx_want = 1'b1;
        rx_addr = rx_desc + ldr_pkg::DW_LENGTH;
      end
      ldr_pkg::RX_READY: begin
        rx_want  = hold_full & (buf_cnt < buf_len);
        rx_we    = 1'b1;
        rx_addr  = {buf_hi, buf_lo} + {12'h000, buf_cnt};
        rx_wdata = hold_data;
        rx_be    = hold_be;
      end
      ldr_pkg::RX_LOOK: begin
        rx_want = 1'b1;
        rx_addr = rx_next + ldr_pkg::DW_STATUS;
      end
      ldr_pkg::RX_CLOSE_LEN: begin
        rx_want  = 1'b1;
        rx_we    = 1'b1;
        rx_addr  = rx_desc + ldr_pkg::DW_PKT_LENGTH;
        rx_wdata = {ldr_pkg::PKT_LEN_PAD, pkt_len};
      end
      ldr_pkg::RX_CLOSE_OWN: begin
        rx_want = 1'b1;
        rx_we   = 1'b1;
      end
      default:               rx_want = 1'b0;
    endcase
  end

  assign rx_advance = rx_ack & (rx_state_reg == ldr_pkg::RX_CLOSE_OWN);

  always_ff @(posedge clk) begin
    if (rst || !ctrl_start_reg) begin
      rx_state_reg <= ldr_pkg::RX_STOP;
      {buf_hi, next_hi, buf_lo} <= 32'h0;
      {buf_len, buf_cnt, pkt_len} <= 36'h0;
      rx_poll_cnt <= 8'h00;
      {seg_first, last_reg, in_pkt_reg, end_pend_reg} <= 4'h8;
      {f_fram, f_ovf, f_crc, f_starved} <= 4'h0;
    end else begin
      case (rx_state_reg)
        ldr_pkg::RX_STOP:  rx_state_reg <= ldr_pkg::RX_OWN;
        ldr_pkg::RX_OWN: if (rx_ack) begin
          buf_hi      <= mem_rdata[7:0];
          rx_poll_cnt <= ldr_pkg::POLL_CYCLES;
          rx_state_reg <= mem_rdata[ldr_pkg::W1_OWN] ? ldr_pkg::RX_ADDR : ldr_pkg::RX_WAIT;
        end
        ldr_pkg::RX_WAIT: begin
          rx_poll_cnt <= rx_poll_cnt - 8'h01;
          if (rx_poll_cnt <= 8'h01) begin
            rx_state_reg <= ldr_pkg::RX_OWN;
          end
        end
        ldr_pkg::RX_ADDR: if (rx_ack) begin
          buf_lo       <= mem_rdata;
          rx_state_reg <= ldr_pkg::RX_LEN;
        end
        ldr_pkg::RX_LEN: if (rx_ack) begin
          buf_len      <= 12'(~mem_rdata[11:0] + 12'h001);
          buf_cnt      <= 12'h000;
          rx_state_reg <= ldr_pkg::RX_READY;
        end
        ldr_pkg::RX_READY: begin
          if (hold_written) begin
            buf_cnt    <= buf_cnt + nbytes;
            pkt_len    <= pkt_len + nbytes;
            in_pkt_reg <= 1'b1;
            if (hold_last) begin
              last_reg     <= 1'b1;
              rx_state_reg <= ldr_pkg::RX_CLOSE_LEN;
            end
          end else if (hold_full && buf_cnt >= buf_len) begin
            rx_state_reg <= ldr_pkg::RX_LOOK;
          end else if (rx_end_now && in_pkt_reg) begin
            last_reg     <= 1'b1;
            rx_state_reg <= ldr_pkg::RX_CLOSE_LEN;
          end
        end
        ldr_pkg::RX_LOOK: if (rx_ack) begin
          if (mem_rdata[ldr_pkg::W1_OWN]) begin
            next_hi      <= mem_rdata[7:0];
            rx_state_reg <= ldr_pkg::RX_CLOSE_OWN;
          end else if (f_ovf) begin
            last_reg     <= 1'b1;
            rx_state_reg <= ldr_pkg::RX_CLOSE_LEN;
          end
        end
        ldr_pkg::RX_CLOSE_LEN: if (rx_ack) begin
          rx_state_reg <= ldr_pkg::RX_CLOSE_OWN;
        end
        ldr_pkg::RX_CLOSE_OWN: if (rx_ack) begin
          if (last_reg) begin
            {seg_first, last_reg, in_pkt_reg, end_pend_reg} <= 4'h8;
            pkt_len      <= 12'h000;
            rx_state_reg <= ldr_pkg::RX_OWN;
          end else begin
            seg_first    <= 1'b0;
            buf_hi       <= next_hi;
            rx_state_reg <= ldr_pkg::RX_ADDR;
          end
        end
        default:           rx_state_reg <= ldr_pkg::RX_STOP;
      endcase
      // flags clear as a descriptor closes; a same-cycle event below still wins
      if (rx_advance) begin
        {f_fram, f_ovf, f_crc, f_starved} <= 4'h0;
      end
      if (rx_valid && !drop_reg && pkt_open_reg && hold_full) begin
        f_ovf <= 1'b1;
      end
      if (rx_valid && rx_last && !take && pkt_open_reg) begin
        end_pend_reg <= 1'b1;
      end
      if (rx_valid && rx_last && (take || pkt_open_reg)) begin
        f_crc  <= rx_crc_bad;
        f_fram <= rx_crc_bad & rx_dribble;
      end
      if (rx_ack && rx_state_reg == ldr_pkg::RX_LOOK && !mem_rdata[ldr_pkg::W1_OWN]) begin
        f_starved <= 1'b1;
      end
    end
  end

  // packets that find no ready buffer are dropped whole and noted
  always_ff @(posedge clk) begin
    if (rst) begin
      missed_reg <= 1'b0;
    end else if (rx_valid && !drop_reg && !pkt_open_reg && !start_ok) begin
      missed_reg <= 1'b1;
    end else if (wr_en && avs_address == ldr_pkg::OFS_STATUS && avs_byteenable[3] &&
                 avs_writedata[ldr_pkg::STAT_MISSED]) begin
      missed_reg <= 1'b0;
    end
  end

  // ==========
  // transmit ring walker
  logic [15:0] tx_w1;
  logic [7:0]  tx_poll_cnt;

  assign tx_req           = (tx_state_reg == ldr_pkg::TX_SEND);
  assign tx_first_segment = tx_w1[ldr_pkg::W1_FIRST];
  assign tx_last_segment  = tx_w1[ldr_pkg::W1_LAST];
  assign tx_advance       = tx_ack & (tx_state_reg == ldr_pkg::TX_CLOSE);

  always_comb begin
    tx_want  = 1'b1;
    tx_we    = 1'b0;
    tx_addr  = tx_desc + ldr_pkg::DW_STATUS;
    tx_wdata = {1'b0, tx_w1[14:0]};
    case (tx_state_reg)
      ldr_pkg::TX_OWN:   tx_want = 1'b1;
      ldr_pkg::TX_ADDR:  tx_addr = tx_desc + ldr_pkg::DW_ADDR_LO;
      ldr_pkg::TX_LEN:   tx_addr = tx_desc + ldr_pkg::DW_LENGTH;
      ldr_pkg::TX_CLOSE: tx_we   = 1'b1;
      default:           tx_want = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst || !ctrl_start_reg) begin
      tx_state_reg  <= ldr_pkg::TX_STOP;
      tx_w1         <= 16'h0000;
      tx_buf_addr   <= 24'h000000;
      tx_buf_length <= 12'h000;
      tx_poll_cnt   <= 8'h00;
    end else begin
      case (tx_state_reg)
        ldr_pkg::TX_STOP:  tx_state_reg <= ldr_pkg::TX_OWN;
        ldr_pkg::TX_OWN: if (tx_ack) begin
          tx_w1       <= mem_rdata;
          tx_poll_cnt <= ldr_pkg::POLL_CYCLES;
          tx_state_reg <= mem_rdata[ldr_pkg::W1_OWN] ? ldr_pkg::TX_ADDR : ldr_pkg::TX_WAIT;
        end
        ldr_pkg::TX_WAIT: begin
          tx_poll_cnt <= tx_poll_cnt - 8'h01;
          if (tx_poll_cnt <= 8'h01) begin
            tx_state_reg <= ldr_pkg::TX_OWN;
          end
        end
        ldr_pkg::TX_ADDR: if (tx_ack) begin
          tx_buf_addr  <= {tx_w1[7:0], mem_rdata};
          tx_state_reg <= ldr_pkg::TX_LEN;
        end
        ldr_pkg::TX_LEN: if (tx_ack) begin
          tx_buf_length <= 12'(~mem_rdata[11:0] + 12'h001);
          tx_state_reg  <= ldr_pkg::TX_SEND;
        end
        ldr_pkg::TX_SEND: if (tx_done) begin
          tx_state_reg <= ldr_pkg::TX_CLOSE;
        end
        ldr_pkg::TX_CLOSE: if (tx_ack) begin
          tx_state_reg <= ldr_pkg::TX_OWN;
        end
        default:           tx_state_reg <= ldr_pkg::TX_STOP;
      endcase
    end
  end
endmodule // ldr_ring_manager

/* sim/ldr_ring_manager_sva.sv */
// assertion checker for the descriptor ring manager ports
`timescale 1ns/10ps
module ldr_sva_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  // buffer ram
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic        mem_ack,
  // transmit
  input wire logic        tx_req,
  input wire logic [23:0] tx_buf_addr,
  input wire logic        tx_done
);
  // bench rings lie below, buffers above
  localparam logic [23:0] RING_TOP = 24'h010000;
  logic w1_wr;
  assign w1_wr = mem_req && mem_we && mem_addr < RING_TOP && mem_addr[2:0] == 3'h2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========
  // handshakes
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus not answered");
  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_wdata) && $stable(mem_we)) else $error("ram request moved");
  a_mem_gap: assert property (mem_req && mem_ack |=> !mem_req) else $error("no idle after ack");
  a_tx_hold: assert property (tx_req && !tx_done |=> tx_req && $stable(tx_buf_addr))
    else $error("transmit offer changed");
  a_tx_end: assert property (tx_req && tx_done |=> !tx_req) else $error("transmit offer kept");
  // ==========
  // descriptor traffic
  a_desc_read: assert property (mem_req && !mem_we |-> mem_addr[2:0] inside {3'h0, 3'h2, 3'h4})
    else $error("descriptor read misplaced");
  a_ring_write: assert property (mem_req && mem_we && mem_addr < RING_TOP
    |-> mem_addr[2:0] inside {3'h2, 3'h6}) else $error("device wrote a host field");
  a_own_given: assert property (w1_wr |-> !mem_wdata[15]) else $error("device kept ownership");
  a_fault_sum: assert property (w1_wr |-> mem_wdata[14] == |mem_wdata[13:10])
    else $error("fault summary wrong");
  a_frame_crc: assert property (w1_wr && mem_wdata[13] |-> mem_wdata[11])
    else $error("framing without crc fault");
  a_starve_ovf: assert property (w1_wr && mem_wdata[10] |-> mem_wdata[12])
    else $error("starved without overflow");
  c_whole: cover property (w1_wr && mem_wdata[9] && mem_wdata[8]);
  c_chain: cover property (w1_wr && mem_wdata[9] && !mem_wdata[8]);
  c_tx: cover property (tx_req && tx_done);
endmodule // ldr_sva_chk

bind ldr_ring_manager ldr_sva_chk u_chk (.clk(clk), .rst(rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
  .tx_req(tx_req), .tx_buf_addr(tx_buf_addr), .tx_done(tx_done));

/* sim/ldr_host_ram.sv */
// host side model: buffer ram shared with the ring manager
`timescale 1ns/10ps
module ldr_host_ram (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // ram port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic [1:0]  mem_be,
  output logic             mem_ack,
  output logic      [15:0] mem_rdata,
  // wait states before each answer
  input  wire logic [1:0]  lag
);
  logic [15:0] ram [int unsigned];
  int          wait_n = 0;
  logic        go;
  function automatic logic [15:0] peek(int unsigned a);
    return ram.exists(a) ? ram[a] : 16'h0000;
  endfunction
  assign go = mem_req && !mem_ack && wait_n >= int'(lag);
  initial mem_ack = 1'b0;
  initial mem_rdata = 16'h0000;
  always @(posedge clk) begin
    wait_n <= (rst || go || !mem_req) ? 0 : wait_n + 1;
    mem_ack <= !rst && go;
    // idle bus shows the inverse
    mem_rdata <= (go && !mem_we) ? peek(mem_addr) : ~mem_rdata;
    // only device writes land here
    if (go && mem_we && mem_be[0]) ram[mem_addr][7:0] <= mem_wdata[7:0];
    if (go && mem_we && mem_be[1]) ram[mem_addr][15:8] <= mem_wdata[15:8];
  end
endmodule // ldr_host_ram

/* sim/lan_descriptor_ring_manager_tb.sv */
// self-checking bench for the descriptor ring manager
`timescale 1ns/10ps
module lan_descriptor_ring_manager_tb;
  localparam logic [23:0] RXB = 24'h000100;
  localparam logic [23:0] TXB = 24'h000200;
  localparam logic [23:0] BUF = 24'h020000;
  logic        clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, seed = 32'h71EB;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        mem_req, mem_we, mem_ack, tx_req, tx_first_segment, tx_last_segment;
  logic [23:0] mem_addr, tx_buf_addr;
  logic [15:0] mem_wdata, mem_rdata;
  logic [1:0]  mem_be, lag = 2'h0;
  logic        rx_valid = 1'b0, rx_last = 1'b0, rx_crc_bad = 1'b0, rx_dribble = 1'b0;
  logic        tx_done = 1'b0, c, d;
  logic [7:0]  rx_data = 8'h00;
  logic [11:0] tx_buf_length;
  logic [7:0]  q [$];
  int          err_total = 0, samples_checked = 0, n;
  ldr_ring_manager u_ldr_ring_manager (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_be, .mem_ack, .mem_rdata, .rx_valid, .rx_data, .rx_last,
    .rx_crc_bad, .rx_dribble, .tx_req, .tx_buf_addr, .tx_buf_length, .tx_first_segment,
    .tx_last_segment, .tx_done);
  ldr_host_ram u_host (.clk, .rst, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be,
    .mem_ack, .mem_rdata, .lag);
  initial forever #20 clk = ~clk;
  // ==========
  // helpers
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] exp_w1(logic f, logic l, logic cr, logic dr);
    return {16'h0, 1'b0, cr, cr & dr, 1'b0, cr, 1'b0, f, l, 8'h02};
  endfunction
  task automatic close_out;
    $display("mismatches %0d of %0d checks", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(logic ok);
    if (!ok) begin
      err_total++;
      $display("BAD %0t wait ran out", $time);
      close_out();
    end
  endtask
  task automatic bus(logic w, logic [4:0] a, logic [31:0] dat);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= dat;
    avs_read <= !w;
    avs_write <= w;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    tmo(n < 50);
  endtask
  // hand over a 64-byte buffer, owner bit last
  task automatic give(logic [23:0] dsc, logic [23:0] b);
    u_host.ram[dsc] = b[15:0];
    u_host.ram[dsc + 4] = 16'hFFC0;
    u_host.ram[dsc + 6] = 16'h0000;
    u_host.ram[dsc + 2] = {8'h80, b[23:16]};
    repeat (100) @(posedge clk);
  endtask
  task automatic wait_free(logic [23:0] a);
    for (n = 0; n < 5000 && u_host.ram[a][15] !== 1'b0; n++) @(posedge clk);
    tmo(n < 5000);
  endtask
  task automatic send(int len, logic cr, logic dr);
    q.delete();
    for (int i = 0; i < len; i++) begin
      seed = lfsr(seed);
      q.push_back(seed[7:0]);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= seed[7:0];
      rx_last <= (i == len - 1);
      rx_crc_bad <= cr;
      rx_dribble <= dr;
      lag <= seed[9:8];
      @(posedge clk);
      rx_valid <= 1'b0;
      repeat (40) @(posedge clk);
    end
  endtask
  task automatic chk_buf(logic [23:0] b, int from, int cnt);
    for (int i = 0; i < cnt; i++)
      chk(32'(u_host.ram[b + 24'(i & ~1)][8 * (i & 1) +: 8]), 32'(q[from + i]));
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, ldr_pkg::OFS_RX_RING, 32'h0);
    chk(rd, ldr_pkg::RING_RESET);
    bus(1'b1, ldr_pkg::OFS_RX_RING, 32'hF9000107);
    bus(1'b0, ldr_pkg::OFS_RX_RING, 32'h0);
    chk(rd, 32'hF9000107 & ldr_pkg::RING_MASK);
    bus(1'b0, 5'h10, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, ldr_pkg::OFS_TX_RING, {8'h00, TXB});
    give(RXB, BUF);
    give(RXB + 8, BUF + 64);
    u_host.ram[TXB + 2] = 16'h0000;
    bus(1'b1, ldr_pkg::OFS_CTRL, 32'h1);
    repeat (100) @(posedge clk);
    // 80 bytes chain across two buffers
    send(80, 1'b0, 1'b0);
    wait_free(RXB + 10);
    chk(32'(u_host.ram[RXB + 2]), exp_w1(1'b1, 1'b0, 1'b0, 1'b0));
    chk(32'(u_host.ram[RXB + 10]), exp_w1(1'b0, 1'b1, 1'b0, 1'b0));
    chk(32'(u_host.ram[RXB + 14]), 32'd80);
    chk_buf(BUF, 0, 64);
    chk_buf(BUF + 64, 64, 16);
    bus(1'b0, ldr_pkg::OFS_STATUS, 32'h0);
    chk(32'(rd[6:0]), 32'h0);
    // one buffer, random faults
    give(RXB, BUF);
    seed = lfsr(seed);
    c = seed[0];
    d = seed[1];
    send(20 + int'(seed[5:2]), c, d);
    wait_free(RXB + 2);
    chk(32'(u_host.ram[RXB + 2]), exp_w1(1'b1, 1'b1, c, d));
    if (!c) chk(32'(u_host.ram[RXB + 6]), 32'(q.size()));
    chk_buf(BUF, 0, q.size());
    // next descriptor host-owned: packet missed
    send(10, 1'b0, 1'b0);
    repeat (200) @(posedge clk);
    bus(1'b0, ldr_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rd[ldr_pkg::STAT_MISSED]}, 32'h1);
    chk(32'(rd[6:0]), 32'h1);
    chk(32'(u_host.ram[RXB + 10]), exp_w1(1'b0, 1'b1, 1'b0, 1'b0));
    bus(1'b1, ldr_pkg::OFS_STATUS, 32'h01000000);
    bus(1'b0, ldr_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, rd[ldr_pkg::STAT_MISSED]}, 32'h0);
    // transmit of one 100-byte buffer
    u_host.ram[TXB] = 16'h4000;
    u_host.ram[TXB + 4] = 16'hFF9C;
    u_host.ram[TXB + 2] = 16'h8301;
    for (n = 0; n < 2000 && tx_req !== 1'b1; n++) @(posedge clk);
    tmo(n < 2000);
    chk({tx_buf_addr, 6'h0, tx_first_segment, tx_last_segment}, {24'h014000, 8'h03});
    chk(32'(tx_buf_length), 32'd100);
    tx_done <= 1'b1;
    @(posedge clk);
    tx_done <= 1'b0;
    wait_free(TXB + 2);
    chk(32'(u_host.ram[TXB + 2]), 32'h0301);
    close_out();
  end
endmodule // lan_descriptor_ring_manager_tb
